// ---- lced_pkg.sv ----
// constants, register map and state codes of the lin configuration and error block
// assumes a 40 MHz ref_clk and a 32-bit classic wishbone register port
package lced_pkg;
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          BAUD_DEFAULT   = 19_200;
    localparam int          BIT_CYC        = CLK_HZ / BAUD_DEFAULT;
    localparam int          BREAK_BITS     = 10;
    localparam int          SYNC_BITS      = 8;
    localparam logic [7:0]  MAX_FRAME_BITS = 8'hAE;
    localparam logic [4:0]  WAIT_TO_BITS   = 5'h14;
    localparam logic [7:0]  SYNC_BYTE      = 8'h55;

    localparam logic [9:0]  IDX_CFG        = 10'h095;
    localparam logic [9:0]  IDX_ERR        = 10'h00A;
    localparam logic [9:0]  IDX_MASK       = 10'h00B;
    localparam logic [9:0]  IDX_CTRL       = 10'h00C;

    localparam int          CFG_EN         = 7;
    localparam int          CFG_MASTER     = 6;
    localparam int          CFG_AUTO       = 5;
    localparam logic [7:0]  CFG_WMASK      = 8'hE0;
    localparam logic [7:0]  CFG_RST        = 8'h00;

    localparam int          ERR_SYNC       = 4;
    localparam int          ERR_PAR        = 3;
    localparam int          ERR_TIMEOUT_ERROR       = 2;
    localparam int          ERR_CHK        = 1;
    localparam int          ERR_BIT        = 0;
    localparam logic [4:0]  ERR_RST        = 5'h00;
    localparam logic [4:0]  MASK_RST       = 5'h00;

    localparam int          CTRL_STOP      = 7;
    localparam int          CTRL_ENH       = 5;
    localparam int          CTRL_DACK      = 4;
    localparam logic [7:0]  CTRL_WMASK     = 8'hB7;
    localparam logic [7:0]  CTRL_RST       = 8'h00;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_BRK  = 5'b00010,
        ST_SYNC = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_FLD  = 5'b10000
    } lced_state_t;
endpackage : lced_pkg

// ---- lced_top.sv ----
// lin configuration register, break/sync checking and frame error detection
// assumes lin_rx, lin_tx and tx_active synchronous to ref_clk; wishbone classic slave
// Contract
// - unit idles while the enable bit is 0, runs when 1.
// - mode bit 0 selects slave, 1 selects master.
// - auto rate bit takes bit time from sync field, slave only; else manual.
// - slave flags sync error when sync edges exceed tolerance.
// - slave flags parity error on a bad identifier.
// - timeout flagged when expected response or data never arrives.
// - timeout on overlong frame or missing acknowledge/stop after first data byte.
// - checksum flag set on mismatch, left clear otherwise.
// - stop bit of every field after the sync field is checked and a bad one flagged.
// - synchronise only when break exceeds ten measured bit times.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module lced_top #(
    parameter logic [15:0] MANUAL_BIT_CYC = 16'(lced_pkg::BIT_CYC)
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [11:0] wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    input  wire logic        lin_rx,
    input  wire logic        lin_tx,
    input  wire logic        tx_active,
    output logic             irq
);
    import lced_pkg::*;

    function automatic logic [7:0] csum_add(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        return t[8] ? t[7:0] + 8'h01 : t[7:0];
    endfunction : csum_add

    function automatic logic parity_bad(input logic [7:0] p);
        return (p[6] != (p[0] ^ p[1] ^ p[2] ^ p[4])) ||
               (p[7] != !(p[1] ^ p[3] ^ p[4] ^ p[5]));
    endfunction : parity_bad

    logic [7:0]  cfg_q, cfg_d, ctrl_q, ctrl_d;
    logic [4:0]  err_q, err_d, mask_q, mask_d, ev;
    logic [31:0] dat_q, dat_d;
    logic        ack_q, ack_d, hw_clr, sync_ok;
    lced_state_t st_q, st_d;
    logic [19:0] cnt_q, cnt_d, brk_q, brk_d, first_q, first_d, last_q, last_d;
    logic [19:0] iv, dv;
    logic [15:0] per_q, per_d, per_m1, new_per;
    logic [2:0]  edg_q, edg_d;
    logic [3:0]  bitn_q, bitn_d, fld_q, fld_d, last_fld;
    logic [7:0]  sh_q, sh_d, sum_q, sum_d, frm_q, frm_d;
    logic [4:0]  idle_q, idle_d;
    logic        bad_q, bad_d, bad_now, rx_q, span_ok, tick;

    wire       en     = cfg_q[CFG_EN];
    wire       master = cfg_q[CFG_MASTER];
    wire       acc    = wb_cyc && wb_stb && !ack_q;
    wire [9:0] idx    = wb_adr[11:2];
    wire       wr     = acc && wb_we && wb_sel[0];
    wire       rd_err = acc && !wb_we && idx == IDX_ERR;

    assign wb_dat_r = dat_q;
    assign wb_ack   = ack_q;
    assign irq      = |(err_q & mask_q);

    // register file
    always_comb begin
        cfg_d  = cfg_q;
        mask_d = mask_q;
        ctrl_d = ctrl_q;
        ack_d  = acc;
        dat_d  = dat_q;
        err_d  = (rd_err ? ERR_RST : err_q) | ev;
        if (hw_clr) begin
            ctrl_d[CTRL_STOP] = 1'b0;
            ctrl_d[CTRL_DACK] = 1'b0;
        end
        if (wr) begin
            case (idx)
                IDX_CFG:  cfg_d  = wb_dat_w[7:0] & CFG_WMASK;
                IDX_MASK: mask_d = wb_dat_w[4:0];
                IDX_CTRL: ctrl_d = wb_dat_w[7:0] & CTRL_WMASK;
                default: ;
            endcase
        end
        if (acc) begin
            case (idx)
                IDX_CFG:  dat_d = {24'h000000, cfg_q};
                IDX_ERR:  dat_d = {27'h0000000, err_q};
                IDX_MASK: dat_d = {27'h0000000, mask_q};
                IDX_CTRL: dat_d = {24'h000000, ctrl_q};
                default:  dat_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q  <= CFG_RST;
            mask_q <= MASK_RST;
            ctrl_q <= CTRL_RST;
            err_q  <= ERR_RST;
            dat_q  <= 32'h00000000;
            ack_q  <= 1'b0;
        end else begin
            cfg_q  <= cfg_d;
            mask_q <= mask_d;
            ctrl_q <= ctrl_d;
            err_q  <= err_d;
            dat_q  <= dat_d;
            ack_q  <= ack_d;
        end
    end

    // frame watcher
    assign tick     = (st_q == ST_WAIT || st_q == ST_FLD) && cnt_q == 20'h00000;
    assign per_m1   = per_q - 16'h0001;
    assign last_fld = {1'b0, ctrl_q[2:0]} + 4'h3;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        per_d   = per_q;
        brk_d   = brk_q;
        first_d = first_q;
        last_d  = last_q;
        edg_d   = edg_q;
        bitn_d  = bitn_q;
        sh_d    = sh_q;
        fld_d   = fld_q;
        sum_d   = sum_q;
        frm_d   = frm_q;
        idle_d  = idle_q;
        bad_d   = bad_q;
        ev      = 5'h00;
        sync_ok = 1'b0;
        hw_clr  = 1'b0;
        iv      = cnt_q - last_q;
        dv      = (iv > first_q) ? iv - first_q : first_q - iv;
        bad_now = bad_q || (edg_q >= 3'h2 && dv > {3'h0, first_q[19:3]});
        span_ok = {1'b0, brk_q, 2'h0} > ({3'h0, cnt_q} * 23'h000005);
        new_per = (cfg_q[CFG_AUTO] && !master) ? cnt_q[18:3] : MANUAL_BIT_CYC;
        case (st_q)
            ST_IDLE: begin
                if (rx_q && !lin_rx) begin
                    st_d   = ST_BRK;
                    cnt_d  = 20'h00000;
                    hw_clr = 1'b1;
                end
            end
            ST_BRK: begin
                cnt_d = cnt_q + 20'h00001;
                if (lin_rx) begin
                    brk_d = cnt_q;
                    cnt_d = 20'h00000;
                    edg_d = 3'h0;
                    bad_d = 1'b0;
                    st_d  = ST_SYNC;
                end
            end
            ST_SYNC: begin
                cnt_d = cnt_q + 20'h00001;
                if (&cnt_q) begin
                    ev[ERR_TIMEOUT_ERROR] = 1'b1;
                    st_d         = ST_IDLE;
                end else if (rx_q && !lin_rx) begin
                    edg_d  = edg_q + 3'h1;
                    last_d = cnt_q;
                    bad_d  = bad_now;
                    if (edg_q == 3'h0) begin
                        cnt_d  = 20'h00001;
                        last_d = 20'h00000;
                    end else if (edg_q == 3'h1) begin
                        first_d = iv;
                    end
                    if (edg_q == 3'h4) begin
                        if (!span_ok) begin
                            st_d = ST_IDLE;
                        end else if (!master && bad_now) begin
                            ev[ERR_SYNC] = 1'b1;
                            st_d         = ST_IDLE;
                        end else begin
                            sync_ok = 1'b1;
                            per_d   = new_per;
                            cnt_d   = {4'h0, new_per - 16'h0001};
                            st_d    = ST_WAIT;
                            fld_d   = 4'h1;
                            frm_d   = 8'h00;
                            idle_d  = 5'h00;
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (rx_q && !lin_rx) begin
                    st_d   = ST_FLD;
                    cnt_d  = {5'h00, per_q[15:1]};
                    bitn_d = 4'h0;
                end else if (tick) begin
                    cnt_d  = {4'h0, per_m1};
                    idle_d = idle_q + 5'h01;
                    frm_d  = frm_q + 8'h01;
                    if (idle_q == WAIT_TO_BITS || frm_q == MAX_FRAME_BITS) begin
                        ev[ERR_TIMEOUT_ERROR] = 1'b1;
                        st_d         = ST_IDLE;
                    end
                end else begin
                    cnt_d = cnt_q - 20'h00001;
                end
            end
            ST_FLD: begin
                if (!tick) begin
                    cnt_d = cnt_q - 20'h00001;
                end else begin
                    cnt_d  = {4'h0, per_m1};
                    bitn_d = bitn_q + 4'h1;
                    frm_d  = frm_q + 8'h01;
                    if (tx_active && lin_rx != lin_tx) begin
                        ev[ERR_BIT] = 1'b1;
                    end
                    if (frm_q == MAX_FRAME_BITS) begin
                        ev[ERR_TIMEOUT_ERROR] = 1'b1;
                        st_d         = ST_IDLE;
                    end else if (bitn_q == 4'h0) begin
                        if (lin_rx) begin
                            st_d = ST_WAIT;
                        end
                    end else if (bitn_q <= 4'h8) begin
                        sh_d = {lin_rx, sh_q[7:1]};
                    end else begin
                        if (!lin_rx) begin
                            ev[ERR_BIT] = 1'b1;
                        end
                        st_d   = ST_WAIT;
                        idle_d = 5'h00;
                        fld_d  = fld_q + 4'h1;
                        if (fld_q == 4'h1) begin
                            if (!master && parity_bad(sh_q)) begin
                                ev[ERR_PAR] = 1'b1;
                            end
                            sum_d = ctrl_q[CTRL_ENH] ? sh_q : 8'h00;
                        end else if (fld_q == last_fld) begin
                            if (sh_q != ~sum_q) begin
                                ev[ERR_CHK] = 1'b1;
                            end
                            st_d = ST_IDLE;
                        end else begin
                            sum_d = csum_add(sum_q, sh_q);
                            if (fld_q == 4'h2 && !ctrl_q[CTRL_DACK] && !ctrl_q[CTRL_STOP]) begin
                                ev[ERR_TIMEOUT_ERROR] = 1'b1;
                            end
                            if (ctrl_q[CTRL_STOP]) begin
                                st_d = ST_IDLE;
                            end
                        end
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (!en) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 20'h00000;
            per_q   <= 16'h0001;
            brk_q   <= 20'h00000;
            first_q <= 20'h00000;
            last_q  <= 20'h00000;
            edg_q   <= 3'h0;
            bitn_q  <= 4'h0;
            sh_q    <= 8'h00;
            fld_q   <= 4'h0;
            sum_q   <= 8'h00;
            frm_q   <= 8'h00;
            idle_q  <= 5'h00;
            bad_q   <= 1'b0;
            rx_q    <= 1'b1;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            per_q   <= per_d;
            brk_q   <= brk_d;
            first_q <= first_d;
            last_q  <= last_d;
            edg_q   <= edg_d;
            bitn_q  <= bitn_d;
            sh_q    <= sh_d;
            fld_q   <= fld_d;
            sum_q   <= sum_d;
            frm_q   <= frm_d;
            idle_q  <= idle_d;
            bad_q   <= bad_d;
            rx_q    <= lin_rx;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence bus_req;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    sequence ack_pulse;
        wb_ack ##1 !wb_ack;
    endsequence

    chk_bus_ack: assert property (bus_req |=> ack_pulse)
        else $error("bus request not acknowledged in one cycle");
    chk_disable_idle: assert property (!en |=> st_q == ST_IDLE)
        else $error("unit active while disabled");
    chk_master_nopar: assert property ($rose(err_q[ERR_PAR]) |-> !$past(master))
        else $error("parity flagged in master mode");
    chk_auto_period: assert property (sync_ok && cfg_q[CFG_AUTO] && !master
        |=> per_q == $past(cnt_q[18:3]))
        else $error("auto bit time not taken from sync");
    chk_sync_flag: assert property (ev[ERR_SYNC] |-> !master ##1 err_q[ERR_SYNC])
        else $error("sync error handling wrong");
    chk_wait_timeout_error: assert property (st_q == ST_WAIT && tick && idle_q == WAIT_TO_BITS
        && !(rx_q && !lin_rx) && en |=> err_q[ERR_TIMEOUT_ERROR] && st_q == ST_IDLE)
        else $error("response timeout missed");
    chk_ack_timeout_error: assert property (st_q == ST_FLD && tick && bitn_q == 4'h9 && fld_q == 4'h2
        && fld_q != last_fld && frm_q != MAX_FRAME_BITS
        && !ctrl_q[CTRL_DACK] && !ctrl_q[CTRL_STOP] |=> err_q[ERR_TIMEOUT_ERROR])
        else $error("missing acknowledge not flagged");
    chk_readback: assert property (st_q == ST_FLD && tick && tx_active
        && lin_rx != lin_tx |=> err_q[ERR_BIT])
        else $error("read-back mismatch not flagged");
    chk_stop_bit: assert property (st_q == ST_FLD && tick && bitn_q == 4'h9
        && frm_q != MAX_FRAME_BITS && !lin_rx |=> err_q[ERR_BIT])
        else $error("bad stop bit not flagged");
    chk_break_len: assert property (sync_ok |-> {1'b0, brk_q, 2'h0}
        > ({3'h0, cnt_q} * 23'h000005) ##1 st_q == ST_WAIT)
        else $error("synchronised on short break");
endmodule : lced_top

// ---- lced_node.sv ----
// lin bus node model that sends frames into the block's receive input
// assumes a pulled-up bus; tasks are called right after a rising edge
`timescale 1ns/1ps
module lced_node (
    input  wire logic ref_clk,
    output logic      lin_rx
);
    int bit_cyc = 16;
    initial lin_rx = 1'b1;
    task automatic drive(input logic v, input int n);
        lin_rx <= v;
        repeat (n) @(posedge ref_clk);
    endtask : drive
    task automatic send_break(input int bits);
        drive(1'b0, bits * bit_cyc);
        drive(1'b1, bit_cyc);
    endtask : send_break
    task automatic send_byte(input logic [7:0] b, input logic stop);
        drive(1'b0, bit_cyc);
        for (int i = 0; i < 8; i++) begin
            drive(b[i], bit_cyc);
        end
        drive(stop, bit_cyc);
        drive(1'b1, bit_cyc);
    endtask : send_byte
    // sync field with bit 4 stretched, so one edge interval drifts
    task automatic send_sync(input int stretch);
        drive(1'b0, bit_cyc);
        for (int i = 0; i < 8; i++) begin
            drive(i[0] ? 1'b0 : 1'b1, (i == 4) ? bit_cyc + stretch : bit_cyc);
        end
        drive(1'b1, 2 * bit_cyc);
    endtask : send_sync
endmodule : lced_node

// ---- tb_top.sv ----
// bench for the lin configuration and error block over wishbone
// assumes lced_node drives lin_rx; manual bit time shortened to 16 cycles
`timescale 1ns/1ps
module tb_top;
    import lced_pkg::*;
    localparam int BT = 16;
    logic        ref_clk   = 1'b0;
    logic        reset_n   = 1'b0;
    logic        wb_cyc    = 1'b0;
    logic        wb_stb    = 1'b0;
    logic        wb_we     = 1'b0;
    logic [11:0] wb_adr    = 12'h000;
    logic [3:0]  wb_sel    = 4'h0;
    logic [31:0] wb_dat_w  = 32'h0;
    logic        lin_tx    = 1'b1;
    logic        tx_active = 1'b0;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        irq;
    logic        lin_rx;
    logic [7:0]  q;
    logic [7:0]  gp;
    int          errors     = 0;
    int          num_checks = 0;
    int          cycles     = 0;

    always #12.5 ref_clk = ~ref_clk;

    lced_top #(.MANUAL_BIT_CYC(16'(BT))) lced_top_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .lin_rx(lin_rx), .lin_tx(lin_tx),
        .tx_active(tx_active), .irq(irq)
    );
    lced_node lced_node_i (.ref_clk(ref_clk), .lin_rx(lin_rx));

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end

    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check8

    task automatic check1(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : check1

    // one classic cycle; read data lands in q
    task automatic xfer(input logic we, input logic [9:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= {idx, 2'b00};
        wb_sel   <= 4'h1;
        wb_dat_w <= {24'h0, d};
        do @(posedge ref_clk); while (wb_ack !== 1'b1);
        q = wb_dat_r[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : xfer

    function automatic logic [7:0] pid_of(input logic [5:0] id);
        pid_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction : pid_of

    // restart unit, clear flags by a read, send break, sync, pid, one data byte, checksum
    task automatic frame(input logic [7:0] cfg, pid, ctl, chk, input int brk, input logic ds);
        xfer(1'b1, IDX_CFG, 8'h00);
        xfer(1'b1, IDX_CFG, cfg);
        xfer(1'b0, IDX_ERR, 8'h00);
        lced_node_i.send_break(brk);
        lced_node_i.send_byte(SYNC_BYTE, 1'b1);
        lced_node_i.send_byte(pid, 1'b1);
        if (ctl !== 8'h00) xfer(1'b1, IDX_CTRL, ctl);
        lced_node_i.send_byte(8'hA5, ds);
        lced_node_i.send_byte(chk, 1'b1);
        repeat (4 * BT) @(posedge ref_clk);
    endtask : frame

    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        xfer(1'b0, IDX_CFG, 8'h00);
        check8("cfg reset", 8'h00, q);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("err reset", 8'h00, q);
        xfer(1'b1, IDX_CFG, 8'hFF);
        xfer(1'b0, IDX_CFG, 8'h00);
        check8("cfg bits", 8'hE0, q);
        xfer(1'b1, 10'h100, 8'hFF);
        xfer(1'b0, 10'h100, 8'h00);
        check8("unmapped", 8'h00, q);
        xfer(1'b1, IDX_MASK, 8'h1F);
        gp = pid_of(6'h12);
        frame(8'h80, gp, 8'h10, 8'h5A, 13, 1'b1);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("good frame", 8'h00, q);
        frame(8'h80, gp, 8'h10, 8'h00, 13, 1'b1);
        check1("irq set", 1'b1, irq);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("chk err", 8'h02, q);
        check1("irq clear", 1'b0, irq);
        xfer(1'b1, IDX_MASK, 8'h00);
        frame(8'h80, gp, 8'h10, 8'h00, 13, 1'b1);
        check1("irq masked", 1'b0, irq);
        xfer(1'b1, IDX_MASK, 8'h1F);
        check1("irq unmasked", 1'b1, irq);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("chk err 2", 8'h02, q);
        frame(8'h80, gp ^ 8'h80, 8'h10, 8'h5A, 13, 1'b1);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("parity", 8'h08, q & 8'h08);
        frame(8'hC0, gp ^ 8'h80, 8'h10, 8'h5A, 13, 1'b1);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("master slave-only", 8'h00, q & 8'h18);
        frame(8'h80, gp, 8'h00, 8'h5A, 13, 1'b1);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("no ack", 8'h04, q & 8'h04);
        frame(8'h80, gp, 8'h10, 8'h5A, 13, 1'b0);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("stop bit", 8'h01, q & 8'h01);
        frame(8'h80, gp, 8'h10, 8'h00, 6, 1'b1);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("short break", 8'h00, q);
        frame(8'h00, gp, 8'h10, 8'h00, 13, 1'b1);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("disabled", 8'h00, q);
        tx_active <= 1'b1;
        lin_tx    <= 1'b0;
        frame(8'h80, gp, 8'h10, 8'h5A, 13, 1'b1);
        tx_active <= 1'b0;
        lin_tx    <= 1'b1;
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("readback", 8'h01, q & 8'h01);
        lced_node_i.bit_cyc = 24;
        frame(8'hA0, gp, 8'h10, 8'h5A, 13, 1'b1);
        lced_node_i.bit_cyc = BT;
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("auto rate", 8'h00, q);
        for (int m = 0; m < 2; m++) begin
            xfer(1'b1, IDX_CFG, 8'h00);
            xfer(1'b1, IDX_CFG, m ? 8'hC0 : 8'h80);
            xfer(1'b0, IDX_ERR, 8'h00);
            lced_node_i.send_break(13);
            lced_node_i.send_sync(8);
            xfer(1'b0, IDX_ERR, 8'h00);
            check8("sync skew", m ? 8'h00 : 8'h10, q & 8'h10);
        end
        xfer(1'b1, IDX_CFG, 8'h00);
        xfer(1'b1, IDX_CFG, 8'h80);
        xfer(1'b0, IDX_ERR, 8'h00);
        lced_node_i.send_break(13);
        lced_node_i.send_byte(SYNC_BYTE, 1'b1);
        repeat (25 * BT) @(posedge ref_clk);
        xfer(1'b0, IDX_ERR, 8'h00);
        check8("idle timeout", 8'h04, q & 8'h04);
        conclude();
    end
endmodule : tb_top
